/* File: src/irfd_defines.svh */
// Purpose: Constants for the infrared remote frame decoder
// Assumes: 50 MHz clock, NEC-style pulse-distance frames
// Notes: Times in microseconds, cycle counts derived from the clock rate
`ifndef IRFD_DEFINES_SVH
`define IRFD_DEFINES_SVH

`define IRFD_CLK_MHZ        50
// Nominal widths in microseconds
`define IRFD_LEAD_MARK_US   9000
`define IRFD_LEAD_SPACE_US  4500
`define IRFD_BIT_MARK_US    560
`define IRFD_ZERO_SPACE_US  560
`define IRFD_ONE_SPACE_US   1690
// Tolerance in percent of nominal
`define IRFD_TOL_PCT        25
// Divides every nominal width; 1 keeps real remote timing
`define IRFD_TIME_DIV       1
`define IRFD_FRAME_BITS     32
`define IRFD_CNT_W          20
`define IRFD_BITCNT_W       6
`define IRFD_ZERO_CNT       20'h0_0000
`define IRFD_ZERO_BITS      6'h00
`define IRFD_ZERO_WORD      32'h0000_0000
`define IRFD_ONE_BIT        6'h01

`endif

/* File: src/irfd_pkg.sv */
// Purpose: Types for the infrared remote frame decoder
// Assumes: Included constants header
// Notes: Result word carries custom code, key code and inverted key code
package irfd_pkg;
    typedef enum logic [2:0] {
        IRFD_IDLE                  = 3'b001,
        IRFD_LEADER_SEEN_STATE     = 3'b010,
        IRFD_PAYLOAD_CAPTURE_STATE = 3'b100
    } irfd_state_t;

    typedef struct packed {
        logic [15:0] custom_code;
        logic [7:0]  key_code;
        logic [7:0]  key_code_n;
    } irfd_result_t;
endpackage : irfd_pkg

/* File: src/irfd_code_detector.sv */
// Purpose: Measures mark and space widths of the demodulated input
// Assumes: ir_rx_n low during a carrier burst, synchronous to clk
// Notes: Classifies each completed space with its preceding mark
`timescale 1ns/1ps
`default_nettype none
`include "irfd_defines.svh"
module irfd_code_detector #(
    parameter int CNT_W    = `IRFD_CNT_W,
    parameter int TIME_DIV = `IRFD_TIME_DIV
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ir_rx_n,
    output logic      lead_hit,
    output logic      bit_hit,
    output logic      bit_val,
    output logic      bad_hit,
    output logic      end_hit
);
    import irfd_pkg::*;

    // ========================================
    // Width limits
    localparam int LM   = `IRFD_LEAD_MARK_US * `IRFD_CLK_MHZ / TIME_DIV;
    localparam int LS   = `IRFD_LEAD_SPACE_US * `IRFD_CLK_MHZ / TIME_DIV;
    localparam int BM   = `IRFD_BIT_MARK_US * `IRFD_CLK_MHZ / TIME_DIV;
    localparam int ZS   = `IRFD_ZERO_SPACE_US * `IRFD_CLK_MHZ / TIME_DIV;
    localparam int OS   = `IRFD_ONE_SPACE_US * `IRFD_CLK_MHZ / TIME_DIV;
    localparam int TP   = `IRFD_TOL_PCT;

    function automatic logic in_win(input logic [CNT_W-1:0] w, input int nom);
        in_win = (int'(w) >= nom - nom * TP / 100) && (int'(w) <= nom + nom * TP / 100);
    endfunction

    // ========================================
    // Edge tracking and width counters
    logic             rx_q;
    logic             mark;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mark_w_q;
    logic             mark_ok_q;
    logic             sat;

    assign mark = ~ir_rx_n;
    assign sat  = &cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_q <= 1'b0;
        end else begin
            rx_q <= mark;
        end
    end

    // Counter saturates so a long idle cannot wrap into a valid width
    always_ff @(posedge clk) begin
        if (rst || (mark != rx_q)) begin
            cnt_q <= '0;
        end else if (!sat) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mark_w_q  <= '0;
            mark_ok_q <= 1'b0;
        end else if (!mark && rx_q) begin
            mark_w_q  <= cnt_q;
            mark_ok_q <= 1'b1;
        end else if (!mark && sat) begin
            mark_ok_q <= 1'b0;
        end
    end

    // ========================================
    // Classification at end of each space
    logic sp_end;
    assign sp_end = mark && !rx_q && mark_ok_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            lead_hit <= 1'b0;
            bit_hit  <= 1'b0;
            bit_val  <= 1'b0;
            bad_hit  <= 1'b0;
            end_hit  <= 1'b0;
        end else begin
            lead_hit <= sp_end && in_win(mark_w_q, LM) && in_win(cnt_q, LS);
            bit_hit  <= sp_end && in_win(mark_w_q, BM) && (in_win(cnt_q, ZS) || in_win(cnt_q, OS));
            bit_val  <= in_win(cnt_q, OS);
            bad_hit  <= sp_end && !(in_win(mark_w_q, LM) && in_win(cnt_q, LS))
                        && !(in_win(mark_w_q, BM) && (in_win(cnt_q, ZS) || in_win(cnt_q, OS)));
            // Trailing end mark followed by a long quiet space
            end_hit  <= !mark && mark_ok_q && sat && in_win(mark_w_q, BM);
        end
    end
endmodule // irfd_code_detector
`default_nettype wire

/* File: src/irfd_decoder.sv */
// Purpose: Infrared remote frame decoder top
// Assumes: Demodulated active-low input, single 50 MHz clock
// Notes: Result held until the next good frame replaces it
`timescale 1ns/1ps
`default_nettype none
`include "irfd_defines.svh"
module irfd_decoder #(
    parameter int NBITS    = `IRFD_FRAME_BITS,
    parameter int CNT_W    = `IRFD_CNT_W,
    parameter int TIME_DIV = `IRFD_TIME_DIV
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           ir_rx_n,
    output irfd_pkg::irfd_result_t result,
    output logic                result_valid,
    output logic                frame_error,
    output irfd_pkg::irfd_state_t  state
);
    import irfd_pkg::*;

    // ========================================
    // Detector
    logic lead_hit;
    logic bit_hit;
    logic bit_val;
    logic bad_hit;
    logic end_hit;

    // Input arrives already demodulated by the receiver
    irfd_code_detector #(
        .CNT_W    (CNT_W),
        .TIME_DIV (TIME_DIV)
    ) u_det (
        .clk      (clk),
        .rst      (rst),
        .ir_rx_n  (ir_rx_n),
        .lead_hit (lead_hit),
        .bit_hit  (bit_hit),
        .bit_val  (bit_val),
        .bad_hit  (bad_hit),
        .end_hit  (end_hit)
    );

    // ========================================
    // Sequencer
    irfd_state_t                state_q;
    irfd_state_t                state_d;
    logic [`IRFD_BITCNT_W-1:0]  nbits_q;
    logic [31:0]                shift_q;
    logic                       full;

    assign full  = (nbits_q == 6'(NBITS));
    assign state = state_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IRFD_IDLE: begin
                if (lead_hit) begin
                    state_d = IRFD_LEADER_SEEN_STATE;
                end
            end
            IRFD_LEADER_SEEN_STATE: begin
                // First data bit is the custom-code LSB
                if (bit_hit) begin
                    state_d = IRFD_PAYLOAD_CAPTURE_STATE;
                end else if (bad_hit || end_hit) begin
                    state_d = IRFD_IDLE;
                end
            end
            IRFD_PAYLOAD_CAPTURE_STATE: begin
                if (bad_hit || end_hit || lead_hit) begin
                    state_d = IRFD_IDLE;
                end
            end
            default: state_d = IRFD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= IRFD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================
    // Payload shift register, LSB first
    logic take;
    assign take = bit_hit && (state_q != IRFD_IDLE) && !full;

    always_ff @(posedge clk) begin
        if (rst || state_q == IRFD_IDLE) begin
            nbits_q <= `IRFD_ZERO_BITS;
            shift_q <= `IRFD_ZERO_WORD;
        end else if (take) begin
            nbits_q <= nbits_q + `IRFD_ONE_BIT;
            shift_q <= {bit_val, shift_q[31:1]};
        end
    end

    // ========================================
    // Result publish on end bit; key check guards against noise
    logic good;
    assign good = end_hit && (state_q == IRFD_PAYLOAD_CAPTURE_STATE) && full
                  && (shift_q[23:16] == ~shift_q[31:24]);

    always_ff @(posedge clk) begin
        if (rst) begin
            result       <= '0;
            result_valid <= 1'b0;
            frame_error  <= 1'b0;
        end else begin
            result_valid <= good;
            frame_error  <= (state_q != IRFD_IDLE) && (state_d == IRFD_IDLE) && !good;
            if (good) begin
                result.custom_code <= shift_q[15:0];
                result.key_code    <= shift_q[23:16];
                result.key_code_n  <= shift_q[31:24];
            end
        end
    end
endmodule // irfd_decoder
`default_nettype wire

/* File: testbench/irfd_remote_model.sv */
// Purpose: Remote plus receiver model
// Assumes: 50 clk cycles per microsecond
// Notes: Line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module irfd_remote_model #(
    parameter int DIV = 1
) (
    input  wire logic clk,
    output var  logic ir_rx_n
);
    // ==========
    // Frame source
    initial ir_rx_n = 1'b1;
    task automatic hold(input logic v, input int us);
        ir_rx_n = v;
        repeat (us * 50 / DIV) @(negedge clk);
    endtask
    // Bad bit gets a space no window accepts
    task automatic send(input logic [31:0] w, input int lead, input int bad);
        hold(1'b0, lead);
        hold(1'b1, 4500);
        for (int i = 0; i < 32; i++) begin
            hold(1'b0, 560);
            hold(1'b1, i == bad ? 3000 : (w[i] ? 1690 : 560));
        end
        hold(1'b0, 560);
        ir_rx_n = 1'b1;
    endtask
endmodule // irfd_remote_model
`default_nettype wire

/* File: testbench/irfd_decoder_props.sv */
// Purpose: Port checker for the decoder
// Assumes: Outputs registered on clk
// Notes: Bind follows the module
`timescale 1ns/1ps
`default_nettype none
module irfd_decoder_props (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ir_rx_n,
    input wire irfd_pkg::irfd_result_t result,
    input wire logic                  result_valid,
    input wire logic                  frame_error,
    input wire irfd_pkg::irfd_state_t  state
);
    import irfd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========
    // Steps
    sequence go_lead; $rose(state == IRFD_LEADER_SEEN_STATE); endsequence
    sequence go_cap; $rose(state == IRFD_PAYLOAD_CAPTURE_STATE); endsequence
    // ==========
    // Rules
    lead_from_idle_a: assert property (
        go_lead |-> $past(state) == IRFD_IDLE && !ir_rx_n) else $error("bad lead entry");
    cap_from_lead_a: assert property (
        go_cap |-> $past(state) == IRFD_LEADER_SEEN_STATE && !ir_rx_n)
        else $error("bad capture entry");
    no_skip_a: assert property (
        state == IRFD_IDLE |=> state != IRFD_PAYLOAD_CAPTURE_STATE) else $error("skip");
    result_hold_a: assert property (
        !result_valid |-> $stable(result)) else $error("result moved");
    key_pair_a: assert property (
        result_valid |-> result.key_code == ~result.key_code_n) else $error("key pair");
    valid_pulse_a: assert property (
        result_valid |=> !result_valid) else $error("valid too long");
    valid_end_a: assert property (
        result_valid |-> ir_rx_n ##[0:2] state == IRFD_IDLE) else $error("no idle");
    error_idle_a: assert property (
        frame_error |-> !result_valid ##[0:2] state == IRFD_IDLE) else $error("err idle");
endmodule // irfd_decoder_props
bind irfd_decoder irfd_decoder_props irfd_decoder_props_inst (.clk(clk), .rst(rst),
    .ir_rx_n(ir_rx_n), .result(result), .result_valid(result_valid),
    .frame_error(frame_error), .state(state));
`default_nettype wire

/* File: testbench/tb_infrared_remote_frame_decoder.sv */
// Purpose: Self-checking decoder bench
// Assumes: Frame timing scaled down by TIME_DIV 1000, short run
// Notes: Events counted per frame
`timescale 1ns/1ps
`default_nettype none
module tb_infrared_remote_frame_decoder;
    import irfd_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    wire logic    ir_rx_n;
    irfd_result_t result;
    logic         result_valid, frame_error, saw_lead, saw_cap;
    irfd_state_t  state;
    int           err_total = 0, tests_run = 0, n_val, n_err;
    always #10 clk = ~clk;
    // Widths scaled down so six frames fit a short run
    localparam int tb_div = 1000;
    irfd_decoder #(.CNT_W(10), .TIME_DIV(tb_div)) irfd_decoder_inst (.clk(clk), .rst(rst),
        .ir_rx_n(ir_rx_n),
        .result(result), .result_valid(result_valid), .frame_error(frame_error),
        .state(state));
    irfd_remote_model #(.DIV(tb_div)) irfd_remote_model_inst (.clk(clk), .ir_rx_n(ir_rx_n));
    always @(posedge clk) begin
        if (result_valid === 1'b1) n_val++;
        if (frame_error === 1'b1) n_err++;
        if (state === IRFD_LEADER_SEEN_STATE) saw_lead = 1'b1;
        if (state === IRFD_PAYLOAD_CAPTURE_STATE) saw_cap = 1'b1;
    end
    // ==========
    // Helpers
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    // Waits past the end-of-frame timeout
    task automatic frame(input logic [31:0] w, input int lead, input int bad);
        n_val = 0;
        n_err = 0;
        saw_lead = 1'b0;
        saw_cap = 1'b0;
        irfd_remote_model_inst.send(w, lead, bad);
        repeat (1_200) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("Checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_keys;
        logic [7:0] k [3] = '{8'h0F, 8'h13, 8'h00};
        foreach (k[i]) begin
            frame({~k[i], k[i], 16'hA55A}, 9000, 99);
            chk(saw_lead && saw_cap, "states");
            chk(n_val == 1 && result === {16'hA55A, k[i], ~k[i]}, "result");
        end
    endtask
    task automatic t_mismatch;
        frame({8'h13, 8'h13, 16'h0000}, 9000, 99);
        chk(n_err == 1 && n_val == 0 && result === 32'hA55A_00FF, "pair");
    endtask
    task automatic t_bad_bit;
        frame(32'h0000_0000, 9000, 5);
        chk(saw_cap && n_err == 1 && n_val == 0, "bad bit");
    endtask
    task automatic t_short_lead;
        frame(32'h0000_0000, 6000, 99);
        chk(!saw_lead && n_err == 0 && n_val == 0, "short lead");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(state === IRFD_IDLE && result === 32'h0000_0000, "reset");
        t_keys();
        t_mismatch();
        t_bad_bit();
        t_short_lead();
        finish_test();
    end
    // Six frames under 6k cycles each at the scaled timing
    initial begin
        repeat (60_000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule // tb_infrared_remote_frame_decoder
`default_nettype wire
